/* File: flash_host_pkg.sv */
// Constants, types and register map of the parallel flash host controller.
package flash_host_pkg;

  // Clock and pin timing; cycle counts round least times up.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_WC_NS       = 90;
  localparam int T_WP_NS       = 50;
  localparam int T_WPH_NS      = 20;
  localparam int T_AA_NS       = 90;
  localparam int T_OD_NS       = 45;
  localparam int T_RP_NS       = 150;
  localparam int T_RWH_NS      = 1000;
  localparam int WC_CYC   =
    (T_WC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WP_CYC   =
    (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WPH_CYC  =
    (T_WPH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AA_CYC   =
    (T_AA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OD_CYC   =
    (T_OD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RP_CYC   =
    (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RWH_CYC  =
    (T_RWH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_LAT = 4;
  localparam int WREC_CYC = (WC_CYC - WP_CYC - 1 > WPH_CYC) ?
                            (WC_CYC - WP_CYC - 1) : WPH_CYC;
  localparam int RACC_CYC = AA_CYC + SYNC_LAT;
  localparam int CNT_W    = 8;

  // Flash bus widths.
  localparam int FLASH_AW = 18;
  localparam int FLASH_DW = 16;

  // Command codes and status bit positions of the flash.
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_CLEAR       = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam int SR_DONE_BIT = 7;
  localparam int SR_ERR_LSB  = 3;
  localparam int SR_ERR_W    = 3;

  // Register map of the controller, byte addresses.
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ADDR     = 8'h04;
  localparam logic [7:0] REG_WDATA    = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;
  localparam logic [7:0] REG_RDATA    = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam int OP_W        = 3;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_ERR_LSB  = 4;
  localparam int ST_SR_LSB   = 8;
  localparam int IRQ_W       = 3;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_ERR     = 1;
  localparam int IRQ_REFUSED = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  typedef enum logic [OP_W-1:0] {
    OP_NONE  = 3'b000,
    OP_WRITE = 3'b001,
    OP_ERASE = 3'b010,
    OP_CLEAR = 3'b011,
    OP_READ  = 3'b100
  } op_t;

  typedef enum logic [2:0] {
    S_RESET = 3'b000,
    S_WAKE  = 3'b001,
    S_IDLE  = 3'b010,
    S_CMD1  = 3'b011,
    S_CMD2  = 3'b100,
    S_POLL  = 3'b101,
    S_READ  = 3'b110
  } seq_t;

  typedef enum logic [2:0] {
    B_IDLE = 3'b000,
    B_WSET = 3'b001,
    B_WLOW = 3'b010,
    B_WREC = 3'b011,
    B_RACC = 3'b100,
    B_RREC = 3'b101
  } phase_t;

  typedef struct packed {
    logic                rd;
    logic [FLASH_AW-1:0] addr;
    logic [FLASH_DW-1:0] data;
  } bus_req_t;

endpackage

/* File: pin_sync.sv */
// Three-stage synchroniser for flash data pins with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q, s2_q, s3_q, q_q, q_d;

  // A bit only moves once the second and third stages agree on it.
  always_comb begin
    q_d = q_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        q_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q  <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= q_d;
    end
  end

  assign q = q_q;
endmodule
`default_nettype wire

/* File: flash_host.sv */
// Host controller that sequences write, erase and status of a parallel flash.
// Functional notes
// - The host writes the read-array code before reading the array again.
// - After a supply error, clear-status precedes any new write or erase.
// - After an erase confirm the host polls until the done flag is one.
// - Each write or erase sequence covers one word or block; it repeats.
// - An erase sends the setup code, then the confirm code in the block.
// - The clear-status code clears the supply, write and erase error flags.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module flash_host (
  input  wire logic                                clk_sys,
  input  wire logic                                rst,
  input  wire logic [7:0]                          reg_addr,
  input  wire logic [31:0]                         reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [31:0]                         reg_rdata,
  output logic                                     irq,
  output logic      [flash_host_pkg::FLASH_AW-1:0] fl_addr,
  input  wire logic [flash_host_pkg::FLASH_DW-1:0] fl_dq_in,
  output logic      [flash_host_pkg::FLASH_DW-1:0] fl_dq_out,
  output logic                                     fl_dq_oe,
  output logic                                     fl_ce_n,
  output logic                                     fl_oe_n,
  output logic                                     fl_we_n,
  output logic                                     fl_rp_n
);
  import flash_host_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [7:0] setup_code(input op_t op);
    case (op)
      OP_WRITE: setup_code = CMD_WRITE_SETUP;
      OP_ERASE: setup_code = CMD_ERASE_SETUP;
      OP_CLEAR: setup_code = CMD_CLEAR;
      default:  setup_code = CMD_READ_ARRAY;
    endcase
  endfunction

  seq_t                  seq_q, seq_d;
  phase_t                ph_q, ph_d;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic [FLASH_AW-1:0]   fa_q, fa_d;
  logic [FLASH_DW-1:0]   fd_q, fd_d, smp_q, smp_d;
  logic                  ce_n_q, ce_n_d, oe_n_q, oe_n_d;
  logic                  we_n_q, we_n_d, dq_oe_q, dq_oe_d, rp_n_q, rp_n_d;
  op_t                   op_q, op_d, new_op;
  logic [FLASH_AW-1:0]   addr_q, addr_d;
  logic [FLASH_DW-1:0]   wdata_q, wdata_d, rdata_q, rdata_d;
  logic [7:0]            sr_q, sr_d;
  logic [SR_ERR_W-1:0]   err_q, err_d;
  logic [IRQ_W-1:0]      istat_q, istat_d, imask_q, imask_d, ev;
  logic [31:0]           rd_q, rd_d;
  logic [FLASH_DW-1:0]   dq_sync;
  bus_req_t              req;
  logic                  bus_done, start, start_ok, wants_prog, op_valid;
  logic                  ev_done, ev_err, clr_err, cap_sr, cap_rd, active;

  pin_sync #(.W(FLASH_DW)) u_dq_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (fl_dq_in),
    .q       (dq_sync)
  );

  // Requests from software; a program op is held off while the supply
  // error is latched, because the flash would only reject it.
  assign new_op     = op_t'(reg_wdata[OP_W-1:0]);
  assign start      = reg_wr && hit(reg_addr, REG_CTRL);
  assign wants_prog = (new_op == OP_WRITE) || (new_op == OP_ERASE);
  assign op_valid   = (new_op != OP_NONE) && (new_op <= OP_READ);
  assign start_ok   = start && (seq_q == S_IDLE) && op_valid &&
                      !(wants_prog && err_q[0]);
  assign active     = (seq_q == S_CMD1) || (seq_q == S_CMD2) ||
                      (seq_q == S_POLL) || (seq_q == S_READ);

  // Bus cycle wanted by the current sequencer step.
  always_comb begin
    req = '0;
    case (seq_q)
      S_CMD1: begin
        req.data = {8'h00, setup_code(op_q)};
      end
      S_CMD2: begin
        req.addr = addr_q;
        req.data = (op_q == OP_ERASE) ? {8'h00, CMD_CONFIRM} : wdata_q;
      end
      S_POLL: begin
        req.rd = 1'b1;
      end
      S_READ: begin
        req.rd   = 1'b1;
        req.addr = addr_q;
      end
      default: begin
        req = '0;
      end
    endcase
  end

  // Sequencer and pin cycle engine.
  always_comb begin
    seq_d    = seq_q;
    ph_d     = ph_q;
    cnt_d    = cnt_q;
    fa_d     = fa_q;
    fd_d     = fd_q;
    smp_d    = smp_q;
    bus_done = 1'b0;
    ev_done  = 1'b0;
    ev_err   = 1'b0;
    clr_err  = 1'b0;
    cap_sr   = 1'b0;
    cap_rd   = 1'b0;
    case (ph_q)
      B_IDLE: begin
        if (active) begin
          fa_d = req.addr;
          fd_d = req.data;
          if (req.rd) begin
            ph_d  = B_RACC;
            cnt_d = CNT_W'(RACC_CYC - 1);
          end else begin
            ph_d  = B_WSET;
            cnt_d = '0;
          end
        end
      end
      B_WSET: begin
        ph_d  = B_WLOW;
        cnt_d = CNT_W'(WP_CYC - 1);
      end
      B_WLOW: begin
        if (cnt_q == '0) begin
          ph_d  = B_WREC;
          cnt_d = CNT_W'(WREC_CYC - 1);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      B_WREC: begin
        if (cnt_q == '0) begin
          ph_d     = B_IDLE;
          bus_done = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      B_RACC: begin
        if (cnt_q == '0) begin
          smp_d = dq_sync;
          ph_d  = B_RREC;
          cnt_d = CNT_W'(OD_CYC - 1);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      B_RREC: begin
        if (cnt_q == '0) begin
          ph_d     = B_IDLE;
          bus_done = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        ph_d = B_IDLE;
      end
    endcase
    case (seq_q)
      S_RESET: begin
        if (cnt_q == '0) begin
          seq_d = S_WAKE;
          cnt_d = CNT_W'(RWH_CYC - 1);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      S_WAKE: begin
        if (cnt_q == '0) begin
          seq_d = S_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      S_IDLE: begin
        if (start_ok) begin
          seq_d = S_CMD1;
        end
      end
      S_CMD1: begin
        if (bus_done) begin
          case (op_q)
            OP_WRITE, OP_ERASE: seq_d = S_CMD2;
            OP_READ:            seq_d = S_READ;
            default: begin
              seq_d   = S_IDLE;
              clr_err = 1'b1;
              ev_done = 1'b1;
            end
          endcase
        end
      end
      S_CMD2: begin
        if (bus_done) begin
          seq_d = S_POLL;
        end
      end
      S_POLL: begin
        // Each poll is a full read cycle; there is no retry limit, a
        // stuck flash keeps the controller busy until reset.
        if (bus_done && smp_q[SR_DONE_BIT]) begin
          seq_d   = S_IDLE;
          cap_sr  = 1'b1;
          ev_done = 1'b1;
          ev_err  = |smp_q[SR_ERR_LSB +: SR_ERR_W];
        end
      end
      S_READ: begin
        if (bus_done) begin
          seq_d   = S_IDLE;
          cap_rd  = 1'b1;
          ev_done = 1'b1;
        end
      end
      default: begin
        seq_d = S_IDLE;
      end
    endcase
    ce_n_d  = !((ph_d != B_IDLE) && (ph_d != B_RREC));
    we_n_d  = (ph_d != B_WLOW);
    oe_n_d  = (ph_d != B_RACC);
    dq_oe_d = (ph_d == B_WSET) || (ph_d == B_WLOW) || (ph_d == B_WREC);
    rp_n_d  = (seq_d != S_RESET);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seq_q   <= S_RESET;
      ph_q    <= B_IDLE;
      cnt_q   <= CNT_W'(RP_CYC - 1);
      fa_q    <= '0;
      fd_q    <= '0;
      smp_q   <= '0;
      ce_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      dq_oe_q <= 1'b0;
      rp_n_q  <= 1'b0;
    end else begin
      seq_q   <= seq_d;
      ph_q    <= ph_d;
      cnt_q   <= cnt_d;
      fa_q    <= fa_d;
      fd_q    <= fd_d;
      smp_q   <= smp_d;
      ce_n_q  <= ce_n_d;
      we_n_q  <= we_n_d;
      oe_n_q  <= oe_n_d;
      dq_oe_q <= dq_oe_d;
      rp_n_q  <= rp_n_d;
    end
  end

  // Software registers; a status bit set in the cycle of its clear stays set.
  assign ev = {start && !start_ok, ev_err, ev_done};

  always_comb begin
    op_d    = start_ok ? new_op : op_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    imask_d = imask_q;
    if (reg_wr && hit(reg_addr, REG_ADDR)) begin
      addr_d = reg_wdata[FLASH_AW-1:0];
    end
    if (reg_wr && hit(reg_addr, REG_WDATA)) begin
      wdata_d = reg_wdata[FLASH_DW-1:0];
    end
    if (reg_wr && hit(reg_addr, REG_IRQ_MASK)) begin
      imask_d = reg_wdata[IRQ_W-1:0];
    end
    istat_d = istat_q;
    if (reg_wr && hit(reg_addr, REG_IRQ_STAT)) begin
      istat_d = istat_q & ~reg_wdata[IRQ_W-1:0];
    end
    istat_d = istat_d | ev;
    rdata_d = cap_rd ? smp_q : rdata_q;
    sr_d    = cap_sr ? smp_q[7:0] : sr_q;
    err_d   = (clr_err ? '0 : err_q) |
              (cap_sr ? smp_q[SR_ERR_LSB +: SR_ERR_W] : '0);
    rd_d    = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:     rd_d = {29'h0, op_q};
        REG_ADDR:     rd_d = {14'h0, addr_q};
        REG_WDATA:    rd_d = {16'h0, wdata_q};
        REG_STATUS: begin
          rd_d[ST_BUSY_BIT]               = (seq_q != S_IDLE);
          rd_d[ST_LOCK_BIT]               = err_q[0];
          rd_d[ST_ERR_LSB +: SR_ERR_W]    = err_q;
          rd_d[ST_SR_LSB +: 8]            = sr_q;
        end
        REG_RDATA:    rd_d = {16'h0, rdata_q};
        REG_IRQ_STAT: rd_d = {29'h0, istat_q};
        REG_IRQ_MASK: rd_d = {29'h0, imask_q};
        default:      rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_q    <= OP_NONE;
      addr_q  <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      sr_q    <= '0;
      err_q   <= '0;
      istat_q <= '0;
      imask_q <= IRQ_MASK_RST;
      rd_q    <= '0;
    end else begin
      op_q    <= op_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      sr_q    <= sr_d;
      err_q   <= err_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      rd_q    <= rd_d;
    end
  end

  assign reg_rdata = rd_q;
  assign irq       = |(istat_q & imask_q);
  assign fl_addr   = fa_q;
  assign fl_dq_out = fd_q;
  assign fl_dq_oe  = dq_oe_q;
  assign fl_ce_n   = ce_n_q;
  assign fl_oe_n   = oe_n_q;
  assign fl_we_n   = we_n_q;
  assign fl_rp_n   = rp_n_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence we_strobe;
    !fl_we_n [*7] ##1 fl_we_n;
  endsequence

  a_clear_code_sent: assert property (
    (seq_q == S_CMD1 && op_q == OP_CLEAR && !fl_we_n)
      |-> fl_dq_oe && fl_dq_out[7:0] == CMD_CLEAR)
    else $error("clear-status code not on the bus");
  a_read_array_code: assert property (
    (seq_q == S_CMD1 && op_q == OP_READ && !fl_we_n)
      |-> fl_dq_out[7:0] == CMD_READ_ARRAY)
    else $error("array read without read-array code");
  a_erase_confirm_addr: assert property (
    (seq_q == S_CMD2 && op_q == OP_ERASE && !fl_we_n)
      |-> fl_dq_out[7:0] == CMD_CONFIRM && fl_addr == addr_q)
    else $error("erase confirm code or block address wrong");
  a_erase_setup_first: assert property (
    (seq_q == S_CMD1 && op_q == OP_ERASE && !fl_we_n)
      |-> fl_dq_out[7:0] == CMD_ERASE_SETUP)
    else $error("erase not opened by setup code");
  a_lock_refuses_prog: assert property (
    (start && wants_prog && err_q[0] && seq_q == S_IDLE)
      |=> seq_q == S_IDLE ##0 istat_q[IRQ_REFUSED])
    else $error("program started while supply error latched");
  a_poll_until_done: assert property (
    (seq_q == S_POLL && bus_done && !smp_q[SR_DONE_BIT])
      |=> seq_q == S_POLL ##1 ph_q == B_RACC && !fl_oe_n)
    else $error("left polling before done flag");
  a_errors_sticky: assert property (
    (err_q != '0 && !clr_err) |=> (err_q & $past(err_q)) == $past(err_q))
    else $error("error flag dropped without clear-status");
  a_sequence_repeat: assert property (
    (seq_q == S_IDLE && start_ok) |=> seq_q == S_CMD1 ##1 ph_q == B_WSET)
    else $error("accepted request did not start a new sequence");
  a_we_pulse_width: assert property (
    $fell(fl_we_n) |-> !fl_ce_n throughout we_strobe)
    else $error("write strobe width wrong");
endmodule
`default_nettype wire

/* File: flash_model.sv */
// Behavioural model of the parallel flash that the host controller drives.
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
  parameter int BUSY_CYC = 40,
  parameter int BLK_AW   = 12
) (
  input  wire logic        clk_sys,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rp_n,
  input  wire logic        vpp_bad,
  input  wire logic        fail_op,
  output logic      [15:0] dq_drv,
  output logic      [7:0]  setups_q
);
  typedef enum logic [1:0] {M_ARRAY, M_STATUS, M_WSET, M_ESET} mode_t;
  mode_t       mode_q;
  logic [7:0]  sr_q;
  logic [15:0] last_q;
  logic        we_q;
  logic        erase_q;
  logic        rd_en;
  int          busy_q;
  logic [15:0] mem [0:(1<<18)-1];

  initial begin
    setups_q = 8'h00;
    last_q = 16'h0000;
    for (int i = 0; i < (1 << 18); i++) mem[i] = 16'hFFFF;
  end

  // Idle lines show the inverse of the last value, never a stale copy.
  assign rd_en  = rp_n && !ce_n && !oe_n;
  assign dq_drv = !rd_en ? ~last_q :
                  (mode_q == M_ARRAY) ? mem[addr] : {8'h00, sr_q};

  // Pins are registered by the host, so edges are seen on the clock.
  always @(posedge clk_sys) begin
    we_q <= we_n;
    if (rd_en) begin
      last_q <= dq_drv;
    end
    if (!rp_n) begin
      mode_q <= M_ARRAY;
      sr_q   <= 8'h80;
      busy_q <= 0;
    end else if (busy_q > 0) begin
      busy_q <= busy_q - 1;
      if (busy_q == 1) begin
        sr_q[7] <= 1'b1;
        if (fail_op) begin
          sr_q[erase_q ? 5 : 4] <= 1'b1;
        end
      end
    end else if (we_n && !we_q && !ce_n) begin
      if (mode_q == M_WSET || mode_q == M_ESET) begin
        mode_q  <= M_STATUS;
        erase_q <= (mode_q == M_ESET);
        if (mode_q == M_ESET && dq[7:0] != 8'hD0) begin
          sr_q[5:4] <= 2'b11;
        end else if (vpp_bad) begin
          sr_q[3] <= 1'b1;
        end else if (!sr_q[3]) begin
          sr_q[7] <= 1'b0;
          busy_q  <= BUSY_CYC;
          if (mode_q == M_WSET) begin
            mem[addr] = mem[addr] & dq;
          end else begin
            for (int i = 0; i < (1 << BLK_AW); i++) begin
              mem[{addr[17:BLK_AW], i[BLK_AW-1:0]}] = 16'hFFFF;
            end
          end
        end
      end else begin
        case (dq[7:0])
          8'hFF: mode_q <= M_ARRAY;
          8'h50: begin
            sr_q[5:3] <= 3'b000;
            mode_q    <= M_STATUS;
          end
          8'h40: begin
            mode_q   <= M_WSET;
            setups_q <= setups_q + 8'h01;
          end
          8'h20: begin
            mode_q   <= M_ESET;
            setups_q <= setups_q + 8'h01;
          end
          default: mode_q <= M_STATUS;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: test_flash_host.sv */
// Self-checking testbench of the parallel flash host controller.
`timescale 1ns/1ps
`default_nettype none
module test_flash_host;
  import flash_host_pkg::*;
  logic        clk_sys   = 1'b0;
  logic        rst       = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        vpp_bad   = 1'b0;
  logic        fail_op   = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq;
  logic [17:0] fl_addr;
  logic [15:0] fl_dq_in;
  logic [15:0] fl_dq_out;
  logic [15:0] mdl_dq;
  logic        fl_dq_oe;
  logic        fl_ce_n;
  logic        fl_oe_n;
  logic        fl_we_n;
  logic        fl_rp_n;
  logic [7:0]  setups;
  logic [7:0]  setups_before;
  int          miscompares     = 0;
  int          samples_checked = 0;

  always #4 clk_sys = ~clk_sys;
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : mdl_dq;

  flash_host dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .fl_addr(fl_addr),
    .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_rp_n(fl_rp_n));

  flash_model mdl (.clk_sys(clk_sys), .addr(fl_addr), .dq(fl_dq_in),
    .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .rp_n(fl_rp_n),
    .vpp_bad(vpp_bad), .fail_op(fail_op), .dq_drv(mdl_dq),
    .setups_q(setups));

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic chk_reg(input string what, input logic [7:0] a,
                         input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp & m, d & m);
  endtask

  task automatic wait_idle();
    logic [31:0] d;
    d = 32'h1;
    for (int i = 0; i < 400 && d[ST_BUSY_BIT] !== 1'b0; i++) begin
      rd(REG_STATUS, d);
    end
    chk("busy clears", 32'h0, {31'h0, d[ST_BUSY_BIT]});
  endtask

  task automatic run(input op_t op);
    wr(REG_CTRL, {29'h0, op});
    wait_idle();
  endtask

  function automatic logic [31:0] st_exp(input logic [2:0] err);
    st_exp = 32'h0;
    st_exp[ST_SR_LSB +: 8]  = 8'h80 | {2'b00, err, 3'b000};
    st_exp[ST_ERR_LSB +: 3] = err;
    st_exp[ST_LOCK_BIT]     = err[0];
  endfunction

  initial begin
    #400000;
    miscompares++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    chk_reg("irq mask", REG_IRQ_MASK, 32'h0, '1);
    chk_reg("unmapped", 8'h40, 32'h0, '1);
    wr(REG_CTRL, {29'h0, OP_WRITE});
    chk_reg("wake refused", REG_IRQ_STAT, 32'h4, '1);
    wr(REG_IRQ_STAT, 32'h7);
    repeat (160) @(posedge clk_sys);
    wr(REG_IRQ_MASK, 32'h7);
    $display("test reset done");

    wr(REG_ADDR, 32'h01234);
    wr(REG_WDATA, 32'hA5C3);
    wr(REG_CTRL, {29'h0, OP_WRITE});
    chk_reg("busy", REG_STATUS, 32'h1, 32'h1);
    wr(REG_CTRL, {29'h0, OP_ERASE});
    wait_idle();
    chk_reg("irq stat", REG_IRQ_STAT, 32'h5, '1);
    chk("irq high", 32'h1, {31'h0, irq});
    chk_reg("status", REG_STATUS, st_exp(3'b000), '1);
    wr(REG_IRQ_STAT, 32'h7);
    // The clear lands on the edge that ended the write; look once it settled.
    @(negedge clk_sys);
    chk("irq low", 32'h0, {31'h0, irq});
    run(OP_READ);
    chk_reg("array", REG_RDATA, 32'hA5C3, '1);
    wr(REG_WDATA, 32'h0F0F);
    run(OP_WRITE);
    run(OP_READ);
    chk_reg("rewrite", REG_RDATA, 32'h0503, '1);
    $display("test write done");

    wr(REG_ADDR, 32'h01000);
    run(OP_ERASE);
    wr(REG_ADDR, 32'h01234);
    run(OP_READ);
    chk_reg("erased", REG_RDATA, 32'hFFFF, '1);
    wr(REG_IRQ_STAT, 32'h7);
    $display("test erase done");

    fail_op <= 1'b1;
    run(OP_WRITE);
    fail_op <= 1'b0;
    chk_reg("write err", REG_STATUS, st_exp(3'b010), '1);
    chk_reg("err irq", REG_IRQ_STAT, 32'h3, '1);
    run(OP_WRITE);
    chk_reg("err sticky", REG_STATUS, st_exp(3'b010), '1);
    run(OP_CLEAR);
    chk_reg("cleared", REG_STATUS, 32'h0, 32'h7F);
    wr(REG_IRQ_STAT, 32'h7);
    $display("test error done");

    wr(REG_IRQ_MASK, 32'h2);
    run(OP_WRITE);
    chk("masked", 32'h0, {31'h0, irq});
    wr(REG_IRQ_MASK, 32'h1);
    chk_reg("unmasked", REG_IRQ_STAT, 32'h1, '1);
    chk("irq unmask", 32'h1, {31'h0, irq});
    wr(REG_IRQ_STAT, 32'h7);
    wr(REG_IRQ_MASK, 32'h7);
    $display("test mask done");

    vpp_bad <= 1'b1;
    run(OP_WRITE);
    vpp_bad <= 1'b0;
    chk_reg("lock", REG_STATUS, st_exp(3'b001), '1);
    setups_before = setups;
    wr(REG_CTRL, {29'h0, OP_ERASE});
    wait_idle();
    chk_reg("lock irq", REG_IRQ_STAT, 32'h7, '1);
    chk("no setup", {24'h0, setups_before}, {24'h0, setups});
    run(OP_CLEAR);
    chk_reg("unlocked", REG_STATUS, 32'h0, 32'h7F);
    run(OP_WRITE);
    chk_reg("after clear", REG_STATUS, st_exp(3'b000), '1);
    $display("test supply done");
    final_report();
  end
endmodule
`default_nettype wire
